// >>> rtl/sgc_pkg.sv
// shared constants and carrier types for the switch global control bank
// assumes an APB slave with 32-bit data, one register per aligned word
package sgc_pkg;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_MGMT_DELAY  = 8'h60;
	localparam logic [7:0] IDX_P5_DELAY    = 8'h65;
	localparam logic [7:0] IDX_WAN_ADDR    = 8'h75;
	localparam logic [7:0] IDX_MGMT_ADDR   = 8'h78;
	localparam logic [7:0] IDX_SOFT_RESET  = 8'h79;
	localparam logic [7:0] IDX_PAUSE_CTRL  = 8'h80;
	localparam logic [7:0] IDX_AGE_CTRL    = 8'h88;
	localparam logic [7:0] IDX_AGE_PORT    = 8'h89;
	localparam logic [7:0] IDX_AGE_VID     = 8'h8A;
	localparam logic [7:0] IDX_AGE_TREE    = 8'h8C;

	// field positions
	localparam int DELAY_RX_BIT   = 1;
	localparam int DELAY_TX_BIT   = 0;
	localparam int SRST_TRIG_BIT  = 7;
	localparam int SRST_ARM_BIT   = 4;
	localparam int PAUSE_SKIP_BIT = 0;
	localparam int AGE_START_BIT  = 7;
	localparam int AGE_GROUP_BIT  = 5;
	localparam int AGE_TREE_BIT   = 4;
	localparam int AGE_VLAN_BIT   = 3;
	localparam int AGE_PORT_BIT   = 2;
	localparam int AGE_DYN_BIT    = 1;
	localparam int AGE_STATIC_BIT = 0;

	// reset values
	localparam logic [4:0]  WAN_ADDR_RST  = 5'h15;
	localparam logic [4:0]  MGMT_ADDR_RST = 5'h18;
	localparam logic [7:0]  BYTE_RST      = 8'h00;
	localparam logic [15:0] VID_REG_RST   = 16'h0000;

	// one address table entry as presented by the table walker
	typedef struct packed {
		logic        valid;
		logic        is_static;
		logic        is_group;
		logic [2:0]  tree_id;
		logic [11:0] vid;
		logic [3:0]  port;
	} sgc_entry_type;

	// aging filter settings
	typedef struct packed {
		logic        age_group_entries;
		logic        age_match_tree;
		logic        age_match_vlan_id;
		logic        age_match_port;
		logic        age_dynamic;
		logic        age_static;
		logic [2:0]  tree_select;
		logic [11:0] quick_age_vid_select;
		logic [3:0]  port_select;
	} sgc_age_filter_type;

	// clock delay enables of one RGMII port
	typedef struct packed {
		logic rx_delay;
		logic tx_delay;
	} sgc_clk_delay_type;

	typedef enum logic [1:0] {
		AGE_IDLE = 2'b00,
		AGE_READ = 2'b01,
		AGE_DONE = 2'b10
	} sgc_age_state_type;

endpackage

// >>> rtl/sgc_age_match.sv
// entry filter of the fast-aging pass
// assumes the entry and filter are stable in the cycle they are judged
`timescale 1ns/1ps
`default_nettype none

module sgc_age_match
(
	input  wire sgc_pkg::sgc_age_filter_type filter_i,
	input  wire sgc_pkg::sgc_entry_type      entry_i,
	output logic                             hit_o
);

	logic type_ok;
	logic group_ok;
	logic tree_ok;
	logic vlan_ok;
	logic port_ok;

	// enabled tree, VLAN and port filters must pass, disabled ones pass; type and group bits admit entries only when set
	always_comb
	begin
		type_ok  = (entry_i.is_static & filter_i.age_static)
			| (~entry_i.is_static & filter_i.age_dynamic);
		group_ok = ~entry_i.is_group | filter_i.age_group_entries;
		tree_ok  = ~filter_i.age_match_tree
			| (entry_i.tree_id == filter_i.tree_select);
		vlan_ok  = ~filter_i.age_match_vlan_id
			| (entry_i.vid == filter_i.quick_age_vid_select);
		port_ok  = ~filter_i.age_match_port
			| (entry_i.port == filter_i.port_select);
		hit_o    = entry_i.valid & type_ok & group_ok & tree_ok & vlan_ok & port_ok;
	end

endmodule

`default_nettype wire

// >>> rtl/sgc_ctrl_regs.sv
// global control register bank of the switch with its fast-aging walker
// assumes an APB master on sys_clk_i and a table walker that answers reads
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - rx delay bit 1 of each port delay register delays receive clock; resets zero.
// - tx delay bit 0 of each port delay register delays transmit clock; resets zero.
// - five-bit WAN PHY polling address, reset 15h, feeds the PHY scanner.
// - five-bit management port PHY address, reset 18h.
// - soft reset asserts on bit 7 with arm bit 4; bit 7 zero releases.
// - pause bit 0 clear checks destination address; set skips the check.
// - writing one to control bit 7 starts a fast-aging pass.
// - hardware clears the start bit when the pass has finished.
// - bit 5 includes group entries in aging; clear excludes them.
// - bit 4 makes aging compare each entry's spanning tree identifier.
// - bit 3 makes aging compare entry VLAN identifier with selected VID.
// - bit 2 makes aging compare entry port with the selected port.
// - bit 1 lets the pass remove dynamically learned matching entries.
// - bit 0 lets the pass remove static matching entries.
// - four-bit port select in bits 3:0, reset zero.
// - twelve-bit VID select in bits 11:0, reset zero.
module sgc_ctrl_regs
#(
	parameter int PADDR_W     = 12,
	parameter int STRAP_W     = 8,
	parameter int TABLE_DEPTH = 1024,
	parameter int INDEX_W     = $clog2(TABLE_DEPTH)
)
(
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	// apb slave
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [PADDR_W-1:0]         paddr_i,
	input  wire logic [31:0]                pwdata_i,
	output logic                            pready_o,
	output logic      [31:0]                prdata_o,
	output logic                            pslverr_o,
	// port controls
	output var   sgc_pkg::sgc_clk_delay_type mgmt_port_delay_o,
	output var   sgc_pkg::sgc_clk_delay_type port5_delay_o,
	output logic      [4:0]                 wan_phy_poll_addr_o,
	output logic      [4:0]                 mgmt_port_phy_addr_o,
	output logic                            pause_dest_check_skip_o,
	// soft reset and straps
	output logic                            soft_reset_o,
	input  wire logic [STRAP_W-1:0]         strap_i,
	output logic      [STRAP_W-1:0]         strap_o,
	// address table walker
	output logic                            at_rd_req_o,
	output logic      [INDEX_W-1:0]         at_rd_index_o,
	input  wire logic                       at_rd_valid_i,
	input  wire sgc_pkg::sgc_entry_type     at_rd_entry_i,
	output logic                            at_remove_o,
	output logic      [INDEX_W-1:0]         at_remove_index_o,
	output logic                            age_busy_o
);

	localparam logic [INDEX_W-1:0] LAST_INDEX = INDEX_W'(TABLE_DEPTH - 1);

	// byte address of a register index
	function automatic logic is_reg(input logic [PADDR_W-1:0] addr, input logic [7:0] idx);
		is_reg = (addr == PADDR_W'({idx, 2'b00}));
	endfunction

	logic                       wr_en;
	logic                       setup_phase;
	logic      [31:0]           rd_value;
	logic                       addr_err;
	logic [7:0]                 wdat;

	sgc_pkg::sgc_clk_delay_type mgmt_delay_reg;
	sgc_pkg::sgc_clk_delay_type p5_delay_reg;
	logic [4:0]                 wan_addr_reg;
	logic [4:0]                 mgmt_addr_reg;
	logic                       srst_trig_reg;
	logic                       srst_arm_reg;
	logic [3:0]                 srst_spare_reg;
	logic                       pause_skip_reg;
	logic                       age_start_reg;
	logic [4:0]                 age_opts_reg;
	logic                       age_group_reg;
	logic [7:0]                 age_port_reg;
	logic [15:0]                age_vid_reg;
	logic [2:0]                 age_tree_reg;
	logic [STRAP_W-1:0]         strap_reg;
	logic [31:0]                prdata_reg;

	sgc_pkg::sgc_age_state_type age_state_reg;
	sgc_pkg::sgc_age_state_type age_state_next;
	logic [INDEX_W-1:0]         age_index_reg;
	logic                       remove_reg;
	logic [INDEX_W-1:0]         remove_index_reg;
	sgc_pkg::sgc_age_filter_type age_filter;
	logic                       entry_hit;
	logic                       age_done;

	// zero wait state: every transfer ends in its first access cycle
	assign pready_o    = 1'b1;
	assign pslverr_o   = psel_i & penable_i & addr_err;
	assign prdata_o    = prdata_reg;
	assign wr_en       = psel_i & penable_i & pwrite_i & ~addr_err;
	assign setup_phase = psel_i & ~penable_i;
	assign wdat        = pwdata_i[7:0];

	// address decode and read mux
	always_comb
	begin
		rd_value = 32'h00000000;
		addr_err = 1'b0;
		if (is_reg(paddr_i, sgc_pkg::IDX_MGMT_DELAY))
			rd_value = {30'h0, mgmt_delay_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_P5_DELAY))
			rd_value = {30'h0, p5_delay_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_WAN_ADDR))
			rd_value = {27'h0, wan_addr_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_MGMT_ADDR))
			rd_value = {27'h0, mgmt_addr_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_SOFT_RESET))
			rd_value = {24'h000000, srst_trig_reg, 2'b00, srst_arm_reg, srst_spare_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_PAUSE_CTRL))
			rd_value = {31'h0, pause_skip_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_AGE_CTRL))
			rd_value = {24'h000000, age_start_reg, 1'b0, age_group_reg, age_opts_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_AGE_PORT))
			rd_value = {24'h000000, age_port_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_AGE_VID))
			rd_value = {16'h0000, age_vid_reg};
		else if (is_reg(paddr_i, sgc_pkg::IDX_AGE_TREE))
			rd_value = {29'h0, age_tree_reg};
		else
			addr_err = 1'b1;
	end

	// read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			prdata_reg <= 32'h00000000;
		else if (setup_phase && !pwrite_i)
			prdata_reg <= rd_value;
	end

	// RGMII clock delay enables of both ports
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			mgmt_delay_reg <= '0;
			p5_delay_reg   <= '0;
		end
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_MGMT_DELAY))
		begin
			mgmt_delay_reg.rx_delay <= wdat[sgc_pkg::DELAY_RX_BIT];
			mgmt_delay_reg.tx_delay <= wdat[sgc_pkg::DELAY_TX_BIT];
		end
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_P5_DELAY))
		begin
			p5_delay_reg.rx_delay <= wdat[sgc_pkg::DELAY_RX_BIT];
			p5_delay_reg.tx_delay <= wdat[sgc_pkg::DELAY_TX_BIT];
		end
	end

	assign mgmt_port_delay_o = mgmt_delay_reg;
	assign port5_delay_o     = p5_delay_reg;

	// PHY addresses used by the MDIO scanner
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			wan_addr_reg  <= sgc_pkg::WAN_ADDR_RST;
			mgmt_addr_reg <= sgc_pkg::MGMT_ADDR_RST;
		end
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_WAN_ADDR))
			wan_addr_reg <= wdat[4:0];
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_MGMT_ADDR))
			mgmt_addr_reg <= wdat[4:0];
	end

	assign wan_phy_poll_addr_o  = wan_addr_reg;
	assign mgmt_port_phy_addr_o = mgmt_addr_reg;

	// guarded soft reset: trigger only counts when armed in the same or the previous soft reset write
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			srst_trig_reg  <= 1'b0;
			srst_arm_reg   <= 1'b0;
			srst_spare_reg <= 4'h0;
		end
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_SOFT_RESET))
		begin
			srst_arm_reg   <= wdat[sgc_pkg::SRST_ARM_BIT];
			srst_spare_reg <= wdat[3:0];
			srst_trig_reg  <= wdat[sgc_pkg::SRST_TRIG_BIT]
				& (wdat[sgc_pkg::SRST_ARM_BIT] | srst_arm_reg);
		end
	end

	assign soft_reset_o = srst_trig_reg;

	// straps follow the pins while either reset is held, frozen afterwards
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || srst_trig_reg)
			strap_reg <= strap_i;
	end

	assign strap_o = strap_reg;

	// pause frame destination address check option
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			pause_skip_reg <= 1'b0;
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_PAUSE_CTRL))
			pause_skip_reg <= wdat[sgc_pkg::PAUSE_SKIP_BIT];
	end

	assign pause_dest_check_skip_o = pause_skip_reg;

	// aging filter selects
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			age_port_reg <= sgc_pkg::BYTE_RST;
			age_vid_reg  <= sgc_pkg::VID_REG_RST;
			age_tree_reg <= 3'h0;
		end
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_AGE_PORT))
			age_port_reg <= wdat;
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_AGE_VID))
			age_vid_reg <= pwdata_i[15:0];
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_AGE_TREE))
			age_tree_reg <= wdat[2:0];
	end

	// aging option bits; software keeps group and port matching exclusive
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			age_opts_reg <= 5'h00;
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_AGE_CTRL))
			age_opts_reg <= wdat[4:0];
	end

	// group aging enable kept apart from the five low option bits
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			age_group_reg <= 1'b0;
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_AGE_CTRL))
			age_group_reg <= wdat[sgc_pkg::AGE_GROUP_BIT];
	end

	// start bit: a software set in the done cycle wins over the clear
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			age_start_reg <= 1'b0;
		else if (wr_en && is_reg(paddr_i, sgc_pkg::IDX_AGE_CTRL)
			&& wdat[sgc_pkg::AGE_START_BIT])
			age_start_reg <= 1'b1;
		else if (age_done)
			age_start_reg <= 1'b0;
	end

	always_comb
	begin
		age_filter.age_group_entries    = age_group_reg;
		age_filter.age_match_tree       = age_opts_reg[sgc_pkg::AGE_TREE_BIT];
		age_filter.age_match_vlan_id    = age_opts_reg[sgc_pkg::AGE_VLAN_BIT];
		age_filter.age_match_port       = age_opts_reg[sgc_pkg::AGE_PORT_BIT];
		age_filter.age_dynamic          = age_opts_reg[sgc_pkg::AGE_DYN_BIT];
		age_filter.age_static           = age_opts_reg[sgc_pkg::AGE_STATIC_BIT];
		age_filter.tree_select          = age_tree_reg;
		age_filter.quick_age_vid_select = age_vid_reg[11:0];
		age_filter.port_select          = age_port_reg[3:0];
	end

	sgc_age_match u_match
	(
		.filter_i (age_filter),
		.entry_i  (at_rd_entry_i),
		.hit_o    (entry_hit)
	);

	// walker state: one table read at a time, held until the walker answers
	always_comb
	begin
		age_state_next = age_state_reg;
		case (age_state_reg)
			sgc_pkg::AGE_IDLE:
				if (age_start_reg)
					age_state_next = sgc_pkg::AGE_READ;
			sgc_pkg::AGE_READ:
				if (at_rd_valid_i && age_index_reg == LAST_INDEX)
					age_state_next = sgc_pkg::AGE_DONE;
			sgc_pkg::AGE_DONE:
				age_state_next = sgc_pkg::AGE_IDLE;
			default:
				age_state_next = sgc_pkg::AGE_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			age_state_reg <= sgc_pkg::AGE_IDLE;
		else
			age_state_reg <= age_state_next;
	end

	// entry index walks the whole table once per pass
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i || age_state_reg == sgc_pkg::AGE_IDLE)
			age_index_reg <= '0;
		else if (age_state_reg == sgc_pkg::AGE_READ && at_rd_valid_i)
			age_index_reg <= age_index_reg + INDEX_W'(1);
	end

	// removal is a one-cycle pulse after the answer, index kept with it
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			remove_reg       <= 1'b0;
			remove_index_reg <= '0;
		end
		else
		begin
			remove_reg <= (age_state_reg == sgc_pkg::AGE_READ)
				& at_rd_valid_i & entry_hit;
			if (age_state_reg == sgc_pkg::AGE_READ && at_rd_valid_i)
				remove_index_reg <= age_index_reg;
		end
	end

	assign age_done          = (age_state_reg == sgc_pkg::AGE_DONE);
	assign at_rd_req_o       = (age_state_reg == sgc_pkg::AGE_READ);
	assign at_rd_index_o     = age_index_reg;
	assign at_remove_o       = remove_reg;
	assign at_remove_index_o = remove_index_reg;
	assign age_busy_o        = (age_state_reg != sgc_pkg::AGE_IDLE);

endmodule

`default_nettype wire

// >>> verification/sgc_ctrl_regs_chk.sv
// assertion checker for the switch global control bank
// assumes it is bound to sgc_ctrl_regs and sees only its ports
`timescale 1ns/1ps
`default_nettype none

module sgc_ctrl_regs_chk
#(
	parameter int PADDR_W = 12,
	parameter int STRAP_W = 8,
	parameter int INDEX_W = 3
)
(
	input  wire logic                       sys_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       psel_i,
	input  wire logic                       penable_i,
	input  wire logic                       pwrite_i,
	input  wire logic [PADDR_W-1:0]         paddr_i,
	input  wire logic [31:0]                pwdata_i,
	input  wire logic                       pready_o,
	input  wire sgc_pkg::sgc_clk_delay_type mgmt_port_delay_o,
	input  wire sgc_pkg::sgc_clk_delay_type port5_delay_o,
	input  wire logic [4:0]                 wan_phy_poll_addr_o,
	input  wire logic [4:0]                 mgmt_port_phy_addr_o,
	input  wire logic                       pause_dest_check_skip_o,
	input  wire logic                       soft_reset_o,
	input  wire logic [STRAP_W-1:0]         strap_i,
	input  wire logic [STRAP_W-1:0]         strap_o,
	input  wire logic                       at_rd_req_o,
	input  wire logic [INDEX_W-1:0]         at_rd_index_o,
	input  wire logic                       at_rd_valid_i,
	input  wire logic                       age_busy_o
);
	logic        wr_en;
	logic [31:0] wd_reg;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	// completed write strobe, data kept one cycle for the compare
	assign wr_en = psel_i && penable_i && pwrite_i && pready_o;
	always_ff @(posedge sys_clk_i)
	begin
		wd_reg <= pwdata_i;
	end

	a_mgmt_delay_wr: assert property (wr_en && paddr_i == 12'h180 |=>
		mgmt_port_delay_o == wd_reg[1:0]) else $error("mgmt delay mismatch");
	a_p5_delay_wr: assert property (wr_en && paddr_i == 12'h194 |=>
		port5_delay_o == wd_reg[1:0]) else $error("port5 delay mismatch");
	a_wan_addr_wr: assert property (wr_en && paddr_i == 12'h1D4 |=>
		wan_phy_poll_addr_o == wd_reg[4:0]) else $error("wan address mismatch");
	a_mgmt_addr_wr: assert property (wr_en && paddr_i == 12'h1E0 |=>
		mgmt_port_phy_addr_o == wd_reg[4:0]) else $error("mgmt address mismatch");
	a_srst_armed_on: assert property (wr_en && paddr_i == 12'h1E4 && pwdata_i[7] &&
		pwdata_i[4] |=> soft_reset_o) else $error("soft reset not raised");
	a_srst_release: assert property (wr_en && paddr_i == 12'h1E4 && !pwdata_i[7]
		|=> !soft_reset_o) else $error("soft reset not released");
	a_strap_resample: assert property (soft_reset_o ##1 soft_reset_o |->
		strap_o == $past(strap_i)) else $error("straps not resampled");
	a_pause_skip_wr: assert property (wr_en && paddr_i == 12'h200 |=>
		pause_dest_check_skip_o == wd_reg[0]) else $error("pause skip mismatch");
	a_age_start: assert property (wr_en && paddr_i == 12'h220 && pwdata_i[7] &&
		!age_busy_o |-> ##[1:2] (at_rd_req_o && age_busy_o)) else $error("aging not started");
	a_req_holds: assert property (at_rd_req_o && !at_rd_valid_i |=>
		at_rd_req_o && $stable(at_rd_index_o)) else $error("table request dropped");
endmodule

bind sgc_ctrl_regs sgc_ctrl_regs_chk #(.PADDR_W(PADDR_W), .STRAP_W(STRAP_W), .INDEX_W(INDEX_W))
	u_chk (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.mgmt_port_delay_o(mgmt_port_delay_o), .port5_delay_o(port5_delay_o),
	.wan_phy_poll_addr_o(wan_phy_poll_addr_o), .mgmt_port_phy_addr_o(mgmt_port_phy_addr_o),
	.pause_dest_check_skip_o(pause_dest_check_skip_o), .soft_reset_o(soft_reset_o),
	.strap_i(strap_i), .strap_o(strap_o), .at_rd_req_o(at_rd_req_o),
	.at_rd_index_o(at_rd_index_o), .at_rd_valid_i(at_rd_valid_i), .age_busy_o(age_busy_o));

`default_nettype wire

// >>> verification/tb.sv
// self-checking bench for the switch global control bank
// assumes an APB slave of any wait states; the table walker is modelled here
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
	logic                   sys_clk_i;
	logic                   rst_i;
	logic                   psel_i;
	logic                   penable_i;
	logic                   pwrite_i;
	logic [11:0]            paddr_i;
	logic [31:0]            pwdata_i;
	logic                   pready_o;
	logic [31:0]            prdata_o;
	logic                   pslverr_o;
	logic                   soft_reset_o;
	logic [7:0]             strap_i;
	logic [7:0]             strap_o;
	logic                   at_rd_req_o;
	logic [2:0]             at_rd_index_o;
	logic                   at_rd_valid_i;
	sgc_pkg::sgc_entry_type at_rd_entry_i;
	logic                   at_remove_o;
	logic [2:0]             at_remove_index_o;
	sgc_pkg::sgc_entry_type tbl [8];
	logic [7:0]             rm_mask;
	logic [31:0]            q;
	logic                   err;
	int                     num_errors;
	int                     num_checks;

	sgc_ctrl_regs #(.TABLE_DEPTH(8)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.mgmt_port_delay_o(), .port5_delay_o(), .wan_phy_poll_addr_o(),
		.mgmt_port_phy_addr_o(), .pause_dest_check_skip_o(), .soft_reset_o(soft_reset_o),
		.strap_i(strap_i), .strap_o(strap_o), .at_rd_req_o(at_rd_req_o),
		.at_rd_index_o(at_rd_index_o), .at_rd_valid_i(at_rd_valid_i),
		.at_rd_entry_i(at_rd_entry_i), .at_remove_o(at_remove_o),
		.at_remove_index_o(at_remove_index_o), .age_busy_o());

	// 200 MHz clock
	initial
	begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// walker answers every other cycle; entry bus toggles when not valid
	always @(posedge sys_clk_i)
	begin
		at_rd_valid_i <= at_rd_req_o && !at_rd_valid_i;
		at_rd_entry_i <= (at_rd_req_o && !at_rd_valid_i) ? tbl[at_rd_index_o] : ~at_rd_entry_i;
		if (at_remove_o === 1'b1)
			rm_mask[at_remove_index_o] = 1'b1;
	end

	// one APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		@(posedge sys_clk_i);
		while (pready_o !== 1'b1)
			@(posedge sys_clk_i);
		q = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// independent reference of the entry selection
	function automatic logic hit(sgc_pkg::sgc_entry_type e, logic [7:0] c, logic [3:0] p,
		logic [11:0] v, logic [2:0] t);
		hit = e.valid && (e.is_static ? c[0] : c[1]) && (!e.is_group || c[5]) &&
			(!c[4] || e.tree_id == t) && (!c[3] || e.vid == v) && (!c[2] || e.port == p);
	endfunction

	// one fast-aging pass with its filters, then compare removals
	task automatic age(input logic [7:0] c, input logic [3:0] p, input logic [11:0] v,
		input logic [2:0] t);
		logic [7:0] ex;
		int         n;
		n = 0;
		apb(1'b1, 12'h224, {28'h0, p});
		apb(1'b1, 12'h228, {20'h0, v});
		apb(1'b1, 12'h230, {29'h0, t});
		rm_mask = 8'h00;
		apb(1'b1, 12'h220, {24'h0, c | 8'h80});
		q = 32'h0000_0080;
		while (q[7] !== 1'b0 && n < 60)
		begin
			apb(1'b0, 12'h220, 32'h0);
			n++;
		end
		`CHK(q[7:0], c)
		for (int i = 0; i < 8; i++)
			ex[i] = hit(tbl[i], c, p, v, t);
		`CHK(rm_mask, ex)
	endtask

	task automatic print_verdict();
		$display("checks=%0d errors=%0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// cut a hang short
	initial
	begin
		#200000;
		num_errors++;
		print_verdict();
	end

	initial
	begin
		logic [11:0] ra [9];
		logic [31:0] rv [9];
		logic [31:0] wm [9];
		ra = '{12'h180, 12'h194, 12'h1D4, 12'h1E0, 12'h200, 12'h220, 12'h224, 12'h228, 12'h230};
		rv = '{0, 0, 32'h15, 32'h18, 0, 0, 0, 0, 0};
		wm = '{3, 3, 32'h1F, 32'h1F, 1, 0, 32'hC, 32'hABC, 5};
		tbl[0] = '{1'b1, 1'b0, 1'b0, 3'h0, 12'h005, 4'h1};
		tbl[1] = '{1'b1, 1'b1, 1'b0, 3'h1, 12'h005, 4'h1};
		tbl[2] = '{1'b1, 1'b0, 1'b1, 3'h2, 12'h005, 4'h2};
		tbl[3] = '{1'b1, 1'b0, 1'b0, 3'h3, 12'h006, 4'h1};
		tbl[4] = '{1'b0, 1'b0, 1'b0, 3'h0, 12'h005, 4'h1};
		tbl[5] = '{1'b1, 1'b1, 1'b0, 3'h3, 12'h005, 4'h2};
		tbl[6] = '{1'b1, 1'b0, 1'b0, 3'h1, 12'h005, 4'h1};
		tbl[7] = '{1'b1, 1'b1, 1'b1, 3'h1, 12'hFFF, 4'hF};
		num_errors = 0;
		num_checks = 0;
		rst_i = 1'b1;
		{psel_i, penable_i, pwrite_i} = 3'b000;
		paddr_i = 12'h000;
		pwdata_i = 32'h0;
		strap_i = 8'h5A;
		at_rd_valid_i = 1'b0;
		at_rd_entry_i = '0;
		rm_mask = 8'h00;
		repeat (4) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		`CHK(strap_o, 8'h5A)
		// reset values, then write and read back with reserved bits masked; the aging control register is only read
		for (int i = 0; i < 9; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			`CHK(q, rv[i])
			if (i != 5)
			begin
				apb(1'b1, ra[i], (i > 5) ? wm[i] : 32'hFFFF_FFFF);
				apb(1'b0, ra[i], 32'h0);
				`CHK(q, wm[i])
			end
		end
		apb(1'b0, 12'h3FC, 32'h0);
		`CHK({err, q}, {1'b1, 32'h0})
		// trigger without arm must not reset
		apb(1'b1, 12'h1E4, 32'h80);
		@(posedge sys_clk_i);
		`CHK(soft_reset_o, 1'b0)
		apb(1'b1, 12'h1E4, 32'h90);
		strap_i <= 8'hC3;
		repeat (3) @(posedge sys_clk_i);
		`CHK({soft_reset_o, strap_o}, {1'b1, 8'hC3})
		apb(1'b1, 12'h1E4, 32'h10);
		strap_i <= 8'h3C;
		repeat (3) @(posedge sys_clk_i);
		`CHK({soft_reset_o, strap_o}, {1'b0, 8'hC3})
		// aging passes over a mixed table
		age(8'h02, 4'h0, 12'h000, 3'h0);
		age(8'h01, 4'h0, 12'h000, 3'h0);
		age(8'h23, 4'h0, 12'h000, 3'h0);
		age(8'h0F, 4'h1, 12'h005, 3'h0);
		age(8'h13, 4'h0, 12'h000, 3'h1);
		print_verdict();
	end
endmodule

`default_nettype wire
